// >>> core/tss_pkg.sv
/*
 * Constants for the transfer switch sequencer: register map, field
 * positions, reset values, timer lengths and state codes.
 * Assumes a 40 MHz pclk and a 0.1 s timebase tick inside the sequencer.
 */
package tss_pkg;

    // ------------------------------------------------------------
    // clock and timebase
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_MS = 100;
    localparam int TICK_NS = TICK_MS * 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 22;

    // ------------------------------------------------------------
    // timer lengths in their own units, then in ticks
    // ------------------------------------------------------------
    localparam int WARMUP_S = 30;
    localparam int NEUTRAL_S = 5;
    localparam int RETURN_S = 30;
    localparam int SET_HOLD_S = 15;
    localparam int MIN_RUN_MIN = 10;
    localparam int COOLDOWN_MIN = 10;
    localparam int EX_NOXFR_MIN = 15;
    localparam int EX_HOLD_MIN = 5;
    localparam int TEST_WEEK_MIN = 39;
    localparam int WEEK_DAYS = 7;

    localparam int WARMUP_TK = WARMUP_S * 1000 / TICK_MS;
    localparam int NEUTRAL_TK = NEUTRAL_S * 1000 / TICK_MS;
    localparam int RETURN_TK = RETURN_S * 1000 / TICK_MS;
    localparam int SET_HOLD_TK = SET_HOLD_S * 1000 / TICK_MS;
    localparam int MIN_RUN_TK = MIN_RUN_MIN * 60000 / TICK_MS;
    localparam int COOLDOWN_TK = COOLDOWN_MIN * 60000 / TICK_MS;
    localparam int EX_NOXFR_TK = EX_NOXFR_MIN * 60000 / TICK_MS;
    localparam int EX_HOLD_TK = EX_HOLD_MIN * 60000 / TICK_MS;
    localparam int TEST_WEEK_TK = TEST_WEEK_MIN * 60000 / TICK_MS;
    localparam int WEEK_TK = WEEK_DAYS * 86400 * (1000 / TICK_MS);

    // fast test and test jumper divide timers by 2**SCALE_SHIFT
    localparam int SCALE_SHIFT = 4;
    localparam int TMR_W = 16;
    localparam int WEEK_W = 23;
    localparam int SET_W = 8;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LID = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    localparam int CTRL_W = 4;
    localparam int CTRL_WARM_BYPASS = 0;
    localparam int CTRL_TRANSFER_ON_EXERCISE_SELECT = 1;
    localparam int CTRL_NEUTRAL_HOLD = 2;
    localparam int CTRL_TEST_JUMPER = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // line-interrupt delay in tenths of a second
    localparam int LID_W = 7;
    localparam logic [6:0] LID_RST = 7'h32;
    localparam logic [6:0] LID_MIN = 7'h01;
    localparam logic [6:0] LID_MAX = 7'h64;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_DROP = 4'b0001,
        ST_START = 4'b0010,
        ST_WARM = 4'b0011,
        ST_NEUT_S = 4'b0100,
        ST_STBY = 4'b0101,
        ST_RET = 4'b0110,
        ST_NEUT_N = 4'b0111,
        ST_COOL = 4'b1000,
        ST_EXRUN = 4'b1001
    } tss_state_t;

endpackage

// >>> core/tss_sequencer.sv
/*
 * Transfer switch sequencer: outage detection, generator start,
 * warm-up, neutral hold, transfer and retransfer, cooldown, seven-day
 * exerciser, fast test and accelerated test, with an APB register slave.
 * Assumes level inputs from external voltage/frequency sensors that are
 * synchronous to pclk, and relay drivers on the outputs.
 */
`timescale 1ns/1ps

module tss_sequencer
    import tss_pkg::*;
#(
    parameter int TICK_LEN = tss_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [tss_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic normal_above_dropout,
    input wire logic normal_above_pickup,
    input wire logic standby_present,
    input wire logic standby_qualified,
    input wire logic fast_test_hold,
    input wire logic exercise_time_set_button,
    output logic gen_start,
    output logic transfer_relay,
    output logic neutral_delay_relay,
    output logic normal_present_lamp,
    output logic standby_position_lamp
);
    import tss_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    tss_state_t state_q, state_d;
    logic [TICK_W-1:0] pre_q;
    logic tick_q;
    logic [TMR_W-1:0] tmr_q, tmr_load;
    logic [TMR_W-1:0] run_q;
    logic [WEEK_W-1:0] week_q;
    logic [SET_W-1:0] set_q;
    logic armed_q, ex_pend_q, ex_q, fast_q, outage_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [LID_W-1:0] lid_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic gen_q, xfer_q, neut_q, nlamp_q, slamp_q;

    // ------------------------------------------------------------
    // decode and control terms
    // ------------------------------------------------------------
    wire warm_bypass = ctrl_q[CTRL_WARM_BYPASS];
    wire transfer_on_exercise_select = ctrl_q[CTRL_TRANSFER_ON_EXERCISE_SELECT];
    wire neutral_hold = ctrl_q[CTRL_NEUTRAL_HOLD];
    wire test_jumper = ctrl_q[CTRL_TEST_JUMPER];
    wire tmr_zero = (tmr_q == '0);
    wire run_done = (run_q == '0);
    wire enter = (state_d != state_q);
    wire take_fast = (state_q == ST_IDLE) && (state_d == ST_START) &&
        fast_test_hold;
    wire take_ex = (state_q == ST_IDLE) && (state_d == ST_START) &&
        !fast_test_hold;
    wire qual_now = (state_q == ST_START) && (state_d != ST_START) &&
        (state_d != ST_IDLE);
    // fast test scales all but neutral hold and line-interrupt delay, jumper scales all
    wire scale_t = fast_q || take_fast || test_jumper;
    wire scale_n = test_jumper;
    wire [WEEK_W-1:0] week_len = test_jumper ? WEEK_W'(TEST_WEEK_TK - 1) :
        WEEK_W'(WEEK_TK - 1);
    wire set_done = tick_q && (set_q == SET_W'(SET_HOLD_TK - 1));
    wire week_due = tick_q && armed_q && (week_q == week_len);
    wire outage_d = !outage_q ? (state_q == ST_DROP && state_d == ST_START)
        : !normal_above_pickup;
    wire lid_wr_ok = (pwdata[LID_W-1:0] >= LID_MIN) &&
        (pwdata[LID_W-1:0] <= LID_MAX);

    // where a transfer to standby goes once warm-up is over
    wire tss_state_t xfer_tgt = neutral_hold ? ST_NEUT_S : ST_STBY;

    function automatic logic [TMR_W-1:0] tss_scale(
        input logic [TMR_W-1:0] v,
        input logic s
    );
        logic [TMR_W-1:0] r;
        r = v >> SCALE_SHIFT;
        if (!s) begin
            tss_scale = v;
        end else if (r == '0) begin
            tss_scale = TMR_W'(1);
        end else begin
            tss_scale = r;
        end
    endfunction

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (!normal_above_dropout) begin
                    state_d = ST_DROP;
                end else if (fast_test_hold || ex_pend_q) begin
                    state_d = ST_START;
                end
            end
            ST_DROP: begin
                if (normal_above_dropout) begin
                    state_d = ST_IDLE;
                end else if (tmr_zero) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                if (!ex_q && !fast_q && !outage_q) begin
                    state_d = ST_IDLE;
                end else if (standby_qualified) begin
                    if (ex_q && !transfer_on_exercise_select) begin
                        state_d = ST_EXRUN;
                    end else if (warm_bypass) begin
                        state_d = xfer_tgt;
                    end else begin
                        state_d = ST_WARM;
                    end
                end
            end
            ST_WARM: begin
                if (!standby_qualified) begin
                    state_d = ST_START;
                end else if (tmr_zero) begin
                    state_d = xfer_tgt;
                end
            end
            ST_NEUT_S: begin
                if (!standby_present) begin
                    state_d = ST_START;
                end else if (tmr_zero) begin
                    state_d = ST_STBY;
                end
            end
            ST_STBY: begin
                if (normal_above_pickup && (ex_q ? tmr_zero :
                        fast_q ? !fast_test_hold : 1'b1)) begin
                    state_d = ST_RET;
                end
            end
            ST_RET: begin
                if (!normal_above_pickup) begin
                    state_d = ST_STBY;
                end else if (tmr_zero) begin
                    state_d = neutral_hold ? ST_NEUT_N : ST_COOL;
                end
            end
            ST_NEUT_N: begin
                if (tmr_zero) begin
                    state_d = ST_COOL;
                end
            end
            ST_COOL: begin
                if (tmr_zero && run_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_EXRUN: begin
                if (tmr_zero && run_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // timer value loaded on entry to a state
    // ------------------------------------------------------------
    always_comb begin
        case (state_d)
            ST_DROP: tmr_load = tss_scale(TMR_W'(lid_q), scale_n);
            ST_WARM: tmr_load = tss_scale(TMR_W'(WARMUP_TK), scale_t);
            ST_NEUT_S, ST_NEUT_N: begin
                tmr_load = tss_scale(TMR_W'(NEUTRAL_TK), scale_n);
            end
            ST_STBY: begin
                tmr_load = ex_q ? tss_scale(TMR_W'(EX_HOLD_TK), scale_t) :
                    '0;
            end
            ST_RET: tmr_load = tss_scale(TMR_W'(RETURN_TK), scale_t);
            ST_COOL: tmr_load = tss_scale(TMR_W'(COOLDOWN_TK), scale_t);
            ST_EXRUN: tmr_load = tss_scale(TMR_W'(EX_NOXFR_TK), scale_t);
            default: tmr_load = '0;
        endcase
    end

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (pre_q == TICK_W'(TICK_LEN - 1));
            pre_q <= (pre_q == TICK_W'(TICK_LEN - 1)) ? '0 : pre_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state, state timer and minimum run timer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            tmr_q <= '0;
            run_q <= '0;
        end else begin
            state_q <= state_d;
            if (enter) begin
                tmr_q <= tmr_load;
            end else if (tick_q && !tmr_zero) begin
                tmr_q <= tmr_q - 1'b1;
            end
            if (qual_now) begin
                run_q <= tss_scale(TMR_W'(MIN_RUN_TK), scale_t);
            end else if (tick_q && !run_done) begin
                run_q <= run_q - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // run cause flags
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ex_q <= 1'b0;
            fast_q <= 1'b0;
            outage_q <= 1'b0;
        end else begin
            ex_q <= take_ex || (ex_q && state_d != ST_IDLE);
            fast_q <= take_fast || (fast_q && state_d != ST_IDLE);
            outage_q <= outage_d;
        end
    end

    // ------------------------------------------------------------
    // seven-day exerciser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_q <= '0;
            armed_q <= 1'b0;
            week_q <= '0;
            ex_pend_q <= 1'b0;
        end else begin
            if (!exercise_time_set_button || armed_q) begin
                set_q <= '0;
            end else if (tick_q) begin
                set_q <= set_q + 1'b1;
            end
            armed_q <= armed_q || set_done;
            if (set_done || week_due) begin
                week_q <= '0;
            end else if (tick_q && armed_q) begin
                week_q <= week_q + 1'b1;
            end
            ex_pend_q <= week_due || (ex_pend_q && !take_ex);
        end
    end

    // ------------------------------------------------------------
    // relay and lamp outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_q <= 1'b0;
            xfer_q <= 1'b0;
            neut_q <= 1'b0;
            nlamp_q <= 1'b0;
            slamp_q <= 1'b0;
        end else begin
            gen_q <= (state_d != ST_IDLE) && (state_d != ST_DROP);
            xfer_q <= (state_d == ST_NEUT_S) || (state_d == ST_STBY) ||
                (state_d == ST_RET);
            neut_q <= (state_d == ST_NEUT_S) ||
                (state_d == ST_NEUT_N);
            nlamp_q <= !outage_d;
            slamp_q <= (state_d == ST_STBY) || (state_d == ST_RET);
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    wire acc = psel && penable && !pready_q;
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_lid = (paddr == ADDR_LID);
    wire hit_stat = (paddr == ADDR_STATUS);
    wire unmapped = !(hit_ctrl || hit_lid || hit_stat);
    wire [31:0] stat_w = {20'h0, slamp_q, outage_q, run_done, ex_pend_q,
        armed_q, neut_q, xfer_q, gen_q, state_q};
    wire [31:0] rdata_w = hit_ctrl ? {28'h0, ctrl_q} :
        hit_lid ? {25'h0, lid_q} : hit_stat ? stat_w : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            lid_q <= LID_RST;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc;
            pslverr_q <= acc && unmapped;
            if (acc && !pwrite) begin
                prdata_q <= rdata_w;
            end
            if (acc && pwrite && hit_ctrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
            if (acc && pwrite && hit_lid && lid_wr_ok) begin
                lid_q <= pwdata[LID_W-1:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gen_start = gen_q;
    assign transfer_relay = xfer_q;
    assign neutral_delay_relay = neut_q;
    assign normal_present_lamp = nlamp_q;
    assign standby_position_lamp = slamp_q;

endmodule

// >>> verif/tss_monitor.sv
/* checker for the tss_sequencer ports.
   assumes one pclk domain, presetn active low; bound at the foot. */
`timescale 1ns/1ps
module tss_monitor
    import tss_pkg::*;
#(
    parameter int TICK_LEN = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic normal_above_dropout,
    input wire logic normal_above_pickup,
    input wire logic standby_present,
    input wire logic standby_qualified,
    input wire logic fast_test_hold,
    input wire logic exercise_time_set_button,
    input wire logic gen_start,
    input wire logic transfer_relay,
    input wire logic neutral_delay_relay,
    input wire logic normal_present_lamp,
    input wire logic standby_position_lamp
);
    localparam int NEUT_LO = (NEUTRAL_TK - 1) * TICK_LEN;
    localparam int NEUT_HI = NEUTRAL_TK * TICK_LEN + 2;
    localparam int RUN_LO = ((MIN_RUN_TK >> SCALE_SHIFT) - 1) * TICK_LEN;
    int neut_q;
    int run_q;
    // -----------------------------------------------
    // relay and engine run lengths
    // -----------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neut_q <= 0;
            run_q <= 0;
        end else begin
            neut_q <= neutral_delay_relay ? neut_q + 1 : 0;
            run_q <= gen_start ? run_q + 1 : 0;
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_wait_s;
        psel && penable && !pready;
    endsequence
    sequence apb_done_s;
        pready ##1 !pready;
    endsequence
    apb_answer_a: assert property (apb_wait_s |=> apb_done_s)
        else $error("pready not a single pulse after access");
    apb_err_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    neut_len_a: assert property (
        $fell(neutral_delay_relay) |-> neut_q >= NEUT_LO && neut_q <= NEUT_HI)
        else $error("neutral hold length wrong");
    xfr_stby_a: assert property (
        $rose(transfer_relay) |-> standby_present)
        else $error("transfer without standby power");
    xfr_qual_a: assert property (
        $rose(transfer_relay) |-> $past(standby_qualified))
        else $error("transfer before standby qualified");
    lamp_stby_a: assert property (
        $rose(standby_position_lamp) |-> transfer_relay)
        else $error("standby lamp without transfer");
    run_xfr_a: assert property (transfer_relay |-> gen_start)
        else $error("load on standby with engine stopped");
    start_cause_a: assert property (
        $rose(gen_start) |->
            $past(!normal_above_dropout || fast_test_hold))
        else $error("engine start without cause");
    lamp_drop_a: assert property (
        $fell(normal_present_lamp) |-> $past(!normal_above_dropout))
        else $error("normal lamp off with normal present");
    stop_min_a: assert property (
        $fell(gen_start) |-> run_q >= RUN_LO && !transfer_relay)
        else $error("engine stopped too early");
endmodule
bind tss_sequencer tss_monitor #(.TICK_LEN(TICK_LEN)) tss_monitor_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .normal_above_dropout(normal_above_dropout),
    .normal_above_pickup(normal_above_pickup),
    .standby_present(standby_present),
    .standby_qualified(standby_qualified),
    .fast_test_hold(fast_test_hold),
    .exercise_time_set_button(exercise_time_set_button),
    .gen_start(gen_start), .transfer_relay(transfer_relay),
    .neutral_delay_relay(neutral_delay_relay),
    .normal_present_lamp(normal_present_lamp),
    .standby_position_lamp(standby_position_lamp)
);

// >>> verif/tss_genset_model.sv
/* engine-generator model for the sequencer bench.
   assumes gen_start high means run; slow stretches cranking. */
`timescale 1ns/1ps
module tss_genset_model #(
    parameter int CRANK_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic gen_start,
    input wire logic slow,
    output logic standby_present,
    output logic standby_qualified
);
    int run_q;
    int lim;
    assign lim = slow ? 8 * CRANK_CYC : CRANK_CYC;
    // engine turns only while start circuit closed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 0;
        end else begin
            run_q <= gen_start ? run_q + 1 : 0;
        end
    end
    // voltage first, then volts and hertz past 80 percent
    assign standby_present = run_q > lim;
    assign standby_qualified = run_q > 2 * lim;
endmodule

// >>> verif/transfer_switch_sequencer_bench.sv
/* self-checking bench for tss_sequencer with a genset model.
   assumes the tss_monitor bind; TICK_LEN shortened to 4. */
`timescale 1ns/1ps
module transfer_switch_sequencer_bench;
    import tss_pkg::*;
    localparam int TL = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic normal_above_dropout, normal_above_pickup, fast_test_hold;
    logic exercise_time_set_button, standby_present, standby_qualified;
    logic gen_start, transfer_relay, neutral_delay_relay;
    logic normal_present_lamp, standby_position_lamp;
    logic [3:0] ctrl_m;
    logic [6:0] lid_m;
    int fails, n_compared, cyc, seed, n, lid;
    tss_sequencer #(.TICK_LEN(TL)) tss_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .normal_above_dropout(normal_above_dropout),
        .normal_above_pickup(normal_above_pickup),
        .standby_present(standby_present),
        .standby_qualified(standby_qualified),
        .fast_test_hold(fast_test_hold),
        .exercise_time_set_button(exercise_time_set_button),
        .gen_start(gen_start), .transfer_relay(transfer_relay),
        .neutral_delay_relay(neutral_delay_relay),
        .normal_present_lamp(normal_present_lamp),
        .standby_position_lamp(standby_position_lamp)
    );
    tss_genset_model tss_genset_model_inst (
        .pclk(pclk), .presetn(presetn), .gen_start(gen_start),
        .slow(slow), .standby_present(standby_present),
        .standby_qualified(standby_qualified)
    );
    always #12.5 pclk = ~pclk;
    // -----------------------------------------------
    // checks and bus tasks
    // -----------------------------------------------
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end
    task automatic vchk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tchk(input int m, input int tk);
        n_compared++;
        if (m < (tk - 1) * TL || m > tk * TL + 6) begin
            fails++;
            $display("ERROR %0t took %0d cycles, %0d ticks due", $time, m, tk);
        end
    endtask
    function automatic logic sig(input int i);
        case (i)
            0: return gen_start;
            1: return transfer_relay;
            2: return neutral_delay_relay;
            3: return standby_qualified;
            default: return standby_position_lamp;
        endcase
    endfunction
    task automatic wait_for(input int i, input logic v, input int lim);
        n = 0;
        while (sig(i) !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        logic err;
        logic [31:0] exp;
        err = a != ADDR_CTRL && a != ADDR_LID && a != ADDR_STATUS;
        exp = a == ADDR_CTRL ? {28'h0, ctrl_m} : {25'h0, lid_m};
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        vchk({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
        if (!w && err) vchk(prdata, 32'h0);
        if (!w && (a == ADDR_CTRL || a == ADDR_LID)) vchk(prdata, exp);
        if (w && a == ADDR_CTRL) ctrl_m = d[3:0];
        if (w && a == ADDR_LID && d >= 1 && d <= 100) lid_m = d[6:0];
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        ctrl_m = CTRL_RST;
        lid_m = LID_RST;
        @(posedge pclk);
    endtask
    task automatic outage();
        normal_above_dropout <= 1'b0;
        normal_above_pickup <= 1'b0;
        wait_for(0, 1'b1, 2000);
    endtask
    task automatic restore();
        normal_above_dropout <= 1'b1;
        normal_above_pickup <= 1'b1;
        wait_for(1, 1'b0, 3000);
        tchk(n, RETURN_TK);
    endtask
    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; slow = 0; fast_test_hold = 0;
        normal_above_dropout = 1; normal_above_pickup = 1;
        exercise_time_set_button = 0; seed = 8;
        do_reset();
        apb(0, ADDR_CTRL, 0);
        apb(0, ADDR_LID, 0);
        apb(0, ADDR_STATUS, 0);
        vchk(prdata, 32'h200);
        apb(0, 8'h0C, 0);
        apb(1, 8'h0C, 32'h5A);
        apb(1, ADDR_STATUS, 32'hFFF);
        apb(1, ADDR_CTRL, 32'hF);
        apb(0, ADDR_CTRL, 0);
        apb(1, ADDR_LID, 32'h65);
        apb(1, ADDR_LID, 0);
        apb(0, ADDR_LID, 0);
        n = 1 + {$random(seed)} % 64;
        exercise_time_set_button <= 1'b1;
        repeat (n * TL) @(posedge pclk);
        exercise_time_set_button <= 1'b0;
        wait_for(0, 1'b1, 1000);
        tchk(n, 250);
        vchk(normal_present_lamp, 1);
        apb(0, ADDR_STATUS, 0);
        vchk(prdata[8:7], 0);
        exercise_time_set_button <= 1'b1;
        repeat ((SET_HOLD_TK + 2) * TL) @(posedge pclk);
        exercise_time_set_button <= 1'b0;
        apb(0, ADDR_STATUS, 0);
        vchk(prdata[8:7], 2'b01);
        lid = 1 + {$random(seed)} % 8;
        slow <= 1'($random(seed));
        apb(1, ADDR_CTRL, 0);
        apb(1, ADDR_LID, lid);
        outage();
        tchk(n, lid);
        @(posedge pclk);
        vchk(normal_present_lamp, 0);
        wait_for(3, 1'b1, 2000);
        wait_for(1, 1'b1, 3000);
        tchk(n, WARMUP_TK);
        wait_for(4, 1'b1, 20);
        tchk(n, 0);
        restore();
        wait_for(0, 1'b0, 30000);
        tchk(n, COOLDOWN_TK);
        vchk(normal_present_lamp, 1);
        apb(1, ADDR_CTRL, 32'h5);
        outage();
        wait_for(3, 1'b1, 2000);
        wait_for(1, 1'b1, 3000);
        tchk(n, 0);
        wait_for(2, 1'b0, 1000);
        tchk(n, NEUTRAL_TK);
        restore();
        wait_for(2, 1'b0, 1000);
        tchk(n, NEUTRAL_TK);
        do_reset();
        vchk({gen_start, normal_present_lamp}, 0);
        @(posedge pclk);
        vchk({gen_start, normal_present_lamp}, 1);
        apb(1, ADDR_CTRL, 32'h4);
        fast_test_hold <= 1'b1;
        wait_for(0, 1'b1, 100);
        wait_for(3, 1'b1, 2000);
        wait_for(1, 1'b1, 1000);
        tchk(n, WARMUP_TK >> SCALE_SHIFT);
        wait_for(2, 1'b0, 1000);
        tchk(n, NEUTRAL_TK);
        fast_test_hold <= 1'b0;
        wait_for(1, 1'b0, 1000);
        tchk(n, RETURN_TK >> SCALE_SHIFT);
        final_report();
    end
endmodule
